// [hdl/urp_packetizer.sv]
`timescale 1ns/1ps
// How it works
// (R01) Format bit 4: eight or seven data bits
// (R02) Format bit 5: two or one stop
// (R03) Bit 6 even/odd, only when parity enabled
// (R04) Parity generated and checked only if bit7
// (R05) Host keeps format low nibble zero
// (R06) Host sets clock source to 32
// (R07) Method 0 launches after idle time
// (R08) Idle time counted in ms after character
// (R09) Method 1 launches on end-of-text value
// (R10) End-of-text byte kept in payload
// (R11) Launch when buffered count reaches maximum
// (R12) Launch on low transmit request pin
// (R13) Command mode: launch at command end only; the code also launches on a low transmit request pin in command mode
// (R14) Command mode gap timeout flushes buffer
// (R15) Drop ready-to-send after threshold bytes
// (R16) Delay serial output after indication pin
// (R17) Nonzero retries request ack, retransmit
// (R18) Ack wait expiry triggers retry
// (R19) Mode 0: no address, deliver all
// (R20) Mode 1: two bytes, match or 255
// (R21) Mode 2: four bytes, net+addr or 255
// (R22) Destinations load defaults, runtime commands change
// (R23) Own ids never 255, same modes
// (R24) Flag bit 7 delivers every frame
// (R25) Any launch forwards all, restarts counters
module urp_packetizer (
	input  wire logic               clk_i,
	input  wire logic               reset_n_i,
	input  wire urp_pkg::urp_cfg_t  cfg_i,
	input  wire logic               serial_rx_i,
	output logic                    serial_tx_o,
	output logic                    rts_n_o,
	input  wire logic               data_request_n_i,
	output logic                    data_indication_n_o,
	input  wire logic               command_mode_i,
	input  wire logic               command_start_seen_i,
	input  wire logic               command_end_i,
	input  wire logic               set_dest_network_command_i,
	input  wire logic               set_dest_address_command_i,
	input  wire logic [7:0]         command_value_i,
	output urp_pkg::urp_byte_t      radio_tx_o,
	output logic                    radio_tx_last_o,
	output logic                    radio_ack_request_o,
	input  wire logic               radio_tx_ready_i,
	input  wire logic               radio_ack_i,
	output logic                    radio_failed_o,
	input  wire urp_pkg::urp_byte_t radio_rx_i,
	input  wire logic               radio_rx_end_i,
	output logic                    parity_error_o
);
	logic       ms_tick;
	logic [2:0] rx_sync_reg;
	logic [2:0] req_sync_reg;
	logic       rx_s;
	logic       req_s;
	logic [7:0] fmt;
	logic [3:0] nbits;
	logic [7:0] dest_net_reg;
	logic [7:0] dest_addr_reg;

	assign fmt   = cfg_i.serial_format_setting;
	assign nbits = fmt[urp_pkg::FMT_LEN8_POS] ? 4'd8 : 4'd7; // [R01]

	function automatic logic par_bit(input logic [7:0] d, input logic [3:0] n, input logic even);
		logic p;
		p = ^(n == 4'd8 ? d : {1'b0, d[6:0]});
		return even ? p : ~p; // [R03]
	endfunction : par_bit

	urp_ms_tick u_tick (
		.clk_i    (clk_i),
		.reset_n_i(reset_n_i),
		.tick_o   (ms_tick)
	);

	// Pins from outside pass three stages; a change counts when stages two and three agree
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rx_sync_reg  <= 3'b111;
			req_sync_reg <= 3'b111;
			rx_s         <= 1'b1;
			req_s        <= 1'b1;
		end else begin
			rx_sync_reg  <= {rx_sync_reg[1:0], serial_rx_i};
			req_sync_reg <= {req_sync_reg[1:0], data_request_n_i};
			if (rx_sync_reg[1] == rx_sync_reg[2])
				rx_s <= rx_sync_reg[2];
			if (req_sync_reg[1] == req_sync_reg[2])
				req_s <= req_sync_reg[2];
		end
	end

	// Serial receiver; the bit time is a fixed cycle count, divisor settings are not modelled
	localparam int unsigned BIT_CYC = urp_pkg::BIT_CYCLES;
	logic [7:0]  brx_cnt_reg;
	logic [3:0]  brx_idx_reg;
	logic [10:0] brx_sh_reg;
	logic        brx_busy_reg;
	logic        rx_prev_reg;
	logic        rx_byte_v;
	logic [7:0]  rx_byte;
	logic [3:0]  frame_len;
	logic [7:0]  rx_word;

	assign frame_len = nbits + (fmt[urp_pkg::FMT_PAR_POS] ? 4'd1 : 4'd0) + 4'd1; // [R04]
	// Data bits sit just above the start bit once the frame has been shifted in
	assign rx_word   = (nbits == 4'd8) ? 8'(brx_sh_reg >> (4'd12 - frame_len))
	                                   : {1'b0, 7'(brx_sh_reg >> (4'd12 - frame_len))}; // [R01]

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			brx_cnt_reg    <= '0;
			brx_idx_reg    <= '0;
			brx_sh_reg     <= '0;
			brx_busy_reg   <= 1'b0;
			rx_prev_reg    <= 1'b1;
			rx_byte_v      <= 1'b0;
			rx_byte        <= '0;
			parity_error_o <= 1'b0;
		end else begin
			rx_prev_reg <= rx_s;
			rx_byte_v   <= 1'b0;
			if (!brx_busy_reg) begin
				if (rx_prev_reg && !rx_s) begin
					brx_busy_reg <= 1'b1;
					brx_cnt_reg  <= 8'(BIT_CYC / 2);
					brx_idx_reg  <= '0;
				end
			end else if (brx_cnt_reg == 8'd0) begin
				brx_cnt_reg <= 8'(BIT_CYC - 1);
				brx_sh_reg  <= {rx_s, brx_sh_reg[10:1]};
				if (brx_idx_reg == frame_len) begin
					brx_busy_reg <= 1'b0;
					rx_byte_v    <= rx_s;
					rx_byte      <= rx_word;
					parity_error_o <= fmt[urp_pkg::FMT_PAR_POS] &&
						(brx_sh_reg[10] != par_bit(rx_word, nbits, fmt[urp_pkg::FMT_EVEN_POS])); // [R04]
				end
				brx_idx_reg <= brx_idx_reg + 1'b1;
			end else begin
				brx_cnt_reg <= brx_cnt_reg - 1'b1;
			end
		end
	end

	// Packet buffer and launch triggers
	logic [7:0] buf_mem [urp_pkg::BUF_DEPTH];
	logic [7:0] count_reg;
	logic [7:0] rd_idx_reg;
	logic [15:0] idle_ms_reg;
	logic       launch;
	logic       flush;
	logic       req_prev_reg;
	logic       sending_reg;
	logic       etx_hit_reg;
	logic       tx_finish;
	urp_pkg::urp_tx_state_t state_reg;

	always_comb begin
		launch = 1'b0;
		flush  = 1'b0;
		if (!sending_reg && count_reg != 8'd0) begin
			if (command_mode_i) begin
				launch = command_end_i; // [R13]
				flush  = command_start_seen_i && idle_ms_reg >= cfg_i.idle_timeout_ms; // [R14]
			end else begin
				if (!cfg_i.packet_method && idle_ms_reg >= cfg_i.idle_timeout_ms)
					launch = 1'b1; // [R07]
				if (cfg_i.packet_method && etx_hit_reg)
					launch = 1'b1; // [R09]
				if (count_reg >= cfg_i.max_packet_bytes)
					launch = 1'b1; // [R11]
			end
			if (req_prev_reg && !req_s && !cfg_i.configuration_flag_word[urp_pkg::CFG_NOREQ_POS])
				launch = 1'b1; // [R12]
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			count_reg    <= '0;
			idle_ms_reg  <= '0;
			req_prev_reg <= 1'b1;
			etx_hit_reg  <= 1'b0;
		end else begin
			req_prev_reg <= req_s;
			if (launch || flush) begin
				idle_ms_reg <= '0; // [R25]
				etx_hit_reg <= 1'b0;
			end else if (rx_byte_v && !sending_reg && count_reg < 8'(urp_pkg::BUF_DEPTH)) begin
				buf_mem[count_reg[6:0]] <= rx_byte; // [R10]
				count_reg   <= count_reg + 1'b1;
				idle_ms_reg <= '0; // [R08]
				etx_hit_reg <= rx_byte == cfg_i.end_of_text_value;
			end else if (ms_tick && idle_ms_reg != 16'hffff) begin
				idle_ms_reg <= idle_ms_reg + 1'b1; // [R08]
			end
			if (flush || (sending_reg && radio_tx_last_o && radio_tx_ready_i && state_reg == urp_pkg::URP_TX_SEND &&
			    !radio_ack_request_o) || tx_finish)
				count_reg <= '0; // [R25]
		end
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i)
			rts_n_o <= 1'b1;
		else
			rts_n_o <= sending_reg || count_reg >= cfg_i.flow_stop_threshold; // [R15]
	end

	// Radio transmit with address header and retries
	logic [2:0]  hdr_idx_reg;
	logic [2:0]  hdr_len;
	logic [7:0]  retry_reg;
	logic [15:0] ack_ms_reg;
	logic [7:0]  hdr_byte;

	always_comb begin
		case (cfg_i.addressing_mode)
			2'd1:    hdr_len = 3'd2; // [R20]
			2'd2:    hdr_len = 3'd4; // [R21]
			default: hdr_len = 3'd0; // [R19]
		endcase
		case (hdr_idx_reg)
			3'd0:    hdr_byte = cfg_i.addressing_mode == 2'd2 ? dest_net_reg : dest_addr_reg;
			3'd1:    hdr_byte = cfg_i.addressing_mode == 2'd2 ? dest_addr_reg : cfg_i.own_device_address;
			3'd2:    hdr_byte = cfg_i.own_network_id;
			default: hdr_byte = cfg_i.own_device_address;
		endcase
	end

	assign sending_reg = state_reg != urp_pkg::URP_TX_IDLE;
	assign tx_finish   = state_reg == urp_pkg::URP_TX_DONE;
	assign radio_ack_request_o = cfg_i.radio_retry_count != 8'd0; // [R17]

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state_reg       <= urp_pkg::URP_TX_IDLE;
			hdr_idx_reg     <= '0;
			rd_idx_reg      <= '0;
			retry_reg       <= '0;
			ack_ms_reg      <= '0;
			radio_tx_o      <= '0;
			radio_tx_last_o <= 1'b0;
			radio_failed_o  <= 1'b0;
		end else begin
			radio_failed_o <= 1'b0;
			case (state_reg)
				urp_pkg::URP_TX_IDLE: begin
					if (launch) begin
						state_reg   <= urp_pkg::URP_TX_SEND;
						hdr_idx_reg <= '0;
						rd_idx_reg  <= '0;
						retry_reg   <= '0;
					end
				end
				urp_pkg::URP_TX_SEND: begin
					if (!radio_tx_o.valid || radio_tx_ready_i) begin
						if (radio_tx_o.valid && radio_tx_last_o) begin
							radio_tx_o <= '0;
							radio_tx_last_o <= 1'b0;
							ack_ms_reg <= '0;
							state_reg  <= radio_ack_request_o ? urp_pkg::URP_TX_WAIT : urp_pkg::URP_TX_DONE;
						end else if (hdr_idx_reg < hdr_len) begin
							radio_tx_o  <= '{valid: 1'b1, data: hdr_byte};
							radio_tx_last_o <= 1'b0;
							hdr_idx_reg <= hdr_idx_reg + 1'b1;
						end else begin
							radio_tx_o  <= '{valid: 1'b1, data: buf_mem[rd_idx_reg[6:0]]};
							radio_tx_last_o <= rd_idx_reg + 1'b1 == count_reg;
							rd_idx_reg  <= rd_idx_reg + 1'b1;
						end
					end
				end
				urp_pkg::URP_TX_WAIT: begin
					if (radio_ack_i) begin
						state_reg <= urp_pkg::URP_TX_DONE;
					end else if (ack_ms_reg >= cfg_i.acknowledge_wait_time) begin
						if (retry_reg >= cfg_i.radio_retry_count) begin // [R17]
							radio_failed_o <= 1'b1;
							state_reg <= urp_pkg::URP_TX_DONE;
						end else begin
							retry_reg   <= retry_reg + 1'b1; // [R18]
							hdr_idx_reg <= '0;
							rd_idx_reg  <= '0;
							state_reg   <= urp_pkg::URP_TX_SEND;
						end
					end else if (ms_tick) begin
						ack_ms_reg <= ack_ms_reg + 1'b1; // [R18]
					end
				end
				urp_pkg::URP_TX_DONE: state_reg <= urp_pkg::URP_TX_IDLE;
				default:              state_reg <= urp_pkg::URP_TX_IDLE;
			endcase
		end
	end

	// Runtime destination, loaded from defaults at reset release
	logic boot_reg;
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			boot_reg      <= 1'b1;
			dest_net_reg  <= '0;
			dest_addr_reg <= '0;
		end else begin
			boot_reg <= 1'b0;
			if (boot_reg) begin
				dest_net_reg  <= cfg_i.default_dest_network; // [R22]
				dest_addr_reg <= cfg_i.default_dest_address;
			end else begin
				if (set_dest_network_command_i)
					dest_net_reg <= command_value_i; // [R22]
				if (set_dest_address_command_i)
					dest_addr_reg <= command_value_i;
			end
		end
	end

	// Receive path: address filter then indication delay then serial output
	logic [2:0]  rxh_idx_reg;
	logic [7:0]  rxh_net_reg;
	logic [7:0]  rxh_addr_reg;
	logic [7:0]  out_mem [urp_pkg::BUF_DEPTH];
	logic [7:0]  out_cnt_reg;
	logic [7:0]  out_rd_reg;
	logic        accept;
	logic        out_pending_reg;
	logic [15:0] di_ms_reg;
	logic        stx_busy_reg;

	always_comb begin
		case (cfg_i.addressing_mode)
			2'd1:    accept = rxh_addr_reg == cfg_i.own_device_address || rxh_addr_reg == urp_pkg::BROADCAST; // [R20]
			2'd2:    accept = (rxh_net_reg == cfg_i.own_network_id && rxh_addr_reg == cfg_i.own_device_address) ||
			                  (rxh_addr_reg == urp_pkg::BROADCAST); // [R21]
			default: accept = 1'b1; // [R19]
		endcase
		if (cfg_i.configuration_flag_word[urp_pkg::CFG_NOADDR_POS])
			accept = 1'b1; // [R24]
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rxh_idx_reg  <= '0;
			rxh_net_reg  <= '0;
			rxh_addr_reg <= '0;
			out_cnt_reg  <= '0;
			out_pending_reg <= 1'b0;
		end else begin
			if (radio_rx_i.valid && !out_pending_reg) begin
				if (rxh_idx_reg < hdr_len) begin
					rxh_idx_reg <= rxh_idx_reg + 1'b1;
					if (rxh_idx_reg == 3'd0 && cfg_i.addressing_mode == 2'd2)
						rxh_net_reg <= radio_rx_i.data;
					else if (rxh_idx_reg == 3'd0 || rxh_idx_reg == 3'd1 && cfg_i.addressing_mode == 2'd2)
						rxh_addr_reg <= radio_rx_i.data;
				end else if (out_cnt_reg < 8'(urp_pkg::BUF_DEPTH)) begin
					out_mem[out_cnt_reg[6:0]] <= radio_rx_i.data;
					out_cnt_reg <= out_cnt_reg + 1'b1;
				end
			end
			if (radio_rx_end_i && !out_pending_reg) begin
				rxh_idx_reg <= '0;
				if (accept && out_cnt_reg != 8'd0)
					out_pending_reg <= 1'b1;
				else
					out_cnt_reg <= '0;
			end
			if (out_pending_reg && out_rd_reg == out_cnt_reg && !stx_busy_reg) begin
				out_pending_reg <= 1'b0;
				out_cnt_reg     <= '0;
			end
		end
	end

	// Serial transmitter with indication delay
	logic [7:0]  stx_cnt_reg;
	logic [3:0]  stx_idx_reg;
	logic [11:0] stx_sh_reg;
	logic [3:0]  stx_len;

	assign stx_len = frame_len + (fmt[urp_pkg::FMT_STOP2_POS] ? 4'd2 : 4'd1); // [R02]

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			data_indication_n_o <= 1'b1;
			di_ms_reg    <= '0;
			out_rd_reg   <= '0;
			stx_cnt_reg  <= '0;
			stx_idx_reg  <= '0;
			stx_sh_reg   <= '1;
			stx_busy_reg <= 1'b0;
			serial_tx_o  <= 1'b1;
		end else begin
			data_indication_n_o <= !out_pending_reg;
			if (!out_pending_reg) begin
				di_ms_reg  <= '0;
				out_rd_reg <= '0;
			end else if (di_ms_reg < cfg_i.indication_output_delay) begin
				if (ms_tick)
					di_ms_reg <= di_ms_reg + 1'b1; // [R16]
			end else if (!stx_busy_reg && out_rd_reg != out_cnt_reg) begin
				stx_busy_reg <= 1'b1;
				stx_cnt_reg  <= 8'(BIT_CYC - 1);
				stx_idx_reg  <= '0;
				stx_sh_reg   <= (nbits == 4'd8)
					? {2'b11, fmt[urp_pkg::FMT_PAR_POS] ? par_bit(out_mem[out_rd_reg[6:0]], nbits,
					   fmt[urp_pkg::FMT_EVEN_POS]) : 1'b1, out_mem[out_rd_reg[6:0]], 1'b0}
					: {3'b111, fmt[urp_pkg::FMT_PAR_POS] ? par_bit(out_mem[out_rd_reg[6:0]], nbits,
					   fmt[urp_pkg::FMT_EVEN_POS]) : 1'b1, out_mem[out_rd_reg[6:0]][6:0], 1'b0}; // [R01] [R04]
				out_rd_reg   <= out_rd_reg + 1'b1;
			end
			if (stx_busy_reg) begin
				serial_tx_o <= stx_sh_reg[0];
				if (stx_cnt_reg == 8'd0) begin
					stx_cnt_reg <= 8'(BIT_CYC - 1);
					stx_sh_reg  <= {1'b1, stx_sh_reg[11:1]};
					stx_idx_reg <= stx_idx_reg + 1'b1;
					if (stx_idx_reg == stx_len - 4'd1)
						stx_busy_reg <= 1'b0; // [R02]
				end else begin
					stx_cnt_reg <= stx_cnt_reg - 1'b1;
				end
			end else begin
				serial_tx_o <= 1'b1;
			end
		end
	end
endmodule : urp_packetizer

// [hdl/urp_pkg.sv]
package urp_pkg;
	localparam int unsigned CLK_HZ         = 25000000;
	localparam int unsigned MS_PER_S       = 1000;
	localparam int unsigned MS_CYCLES      = CLK_HZ / MS_PER_S;
	localparam logic [7:0]  FMT_RESET      = 8'h10;
	localparam int unsigned FMT_LEN8_POS   = 4;
	localparam int unsigned FMT_STOP2_POS  = 5;
	localparam int unsigned FMT_EVEN_POS   = 6;
	localparam int unsigned FMT_PAR_POS    = 7;
	localparam logic [7:0]  BROADCAST      = 8'hff;
	localparam int unsigned CFG_NOADDR_POS = 7;
	localparam int unsigned CFG_NOREQ_POS  = 1;
	localparam int unsigned BUF_DEPTH      = 128;
	localparam logic [7:0]  PKT_SIZE_RESET = 8'h80;
	localparam logic [7:0]  RTS_RESET      = 8'h70;
	localparam logic [7:0]  ETX_RESET      = 8'h0a;
	localparam logic [15:0] TIMEOUT_RESET  = 16'h0005;
	localparam logic [15:0] ACKWAIT_RESET  = 16'h000a;
	localparam int unsigned BIT_CYCLES     = 217;

	typedef struct packed {
		logic [7:0]  serial_format_setting;
		logic        packet_method;
		logic [7:0]  max_packet_bytes;
		logic [7:0]  flow_stop_threshold;
		logic [7:0]  end_of_text_value;
		logic [15:0] idle_timeout_ms;
		logic [15:0] indication_output_delay;
		logic [7:0]  radio_retry_count;
		logic [1:0]  addressing_mode;
		logic [7:0]  default_dest_network;
		logic [7:0]  default_dest_address;
		logic [7:0]  own_network_id;
		logic [7:0]  own_device_address;
		logic [15:0] acknowledge_wait_time;
		logic [15:0] configuration_flag_word;
	} urp_cfg_t;

	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} urp_byte_t;

	typedef enum logic [1:0] {
		URP_TX_IDLE = 2'b00,
		URP_TX_SEND = 2'b01,
		URP_TX_WAIT = 2'b11,
		URP_TX_DONE = 2'b10
	} urp_tx_state_t;
endpackage : urp_pkg

// [hdl/urp_ms_tick.sv]
`timescale 1ns/1ps
module urp_ms_tick (
	input  wire logic clk_i,
	input  wire logic reset_n_i,
	output logic      tick_o
);
	logic [$clog2(urp_pkg::MS_CYCLES)-1:0] cnt_reg;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_reg <= '0;
			tick_o  <= 1'b0;
		end else if (cnt_reg == ($bits(cnt_reg))'(urp_pkg::MS_CYCLES - 1)) begin
			cnt_reg <= '0;
			tick_o  <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 1'b1;
			tick_o  <= 1'b0;
		end
	end
endmodule : urp_ms_tick

// [verif/urp_checker.sv]
`timescale 1ns/1ps
module urp_checker (
	input wire logic               clk_i,
	input wire logic               reset_n_i,
	input wire urp_pkg::urp_cfg_t  cfg_i,
	input wire logic               serial_tx_o,
	input wire logic               rts_n_o,
	input wire logic               data_indication_n_o,
	input wire urp_pkg::urp_byte_t radio_tx_o,
	input wire logic               radio_tx_last_o,
	input wire logic               radio_ack_request_o,
	input wire logic               radio_tx_ready_i,
	input wire logic               radio_failed_o,
	input wire logic               radio_rx_end_i
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);

	a_ack_request: assert property (
		radio_ack_request_o == (cfg_i.radio_retry_count != 8'h00)) else $error("ack request level wrong");
	a_tx_held: assert property (
		radio_tx_o.valid && !radio_tx_ready_i |=> radio_tx_o.valid && $stable(radio_tx_o.data)
		&& $stable(radio_tx_last_o)) else $error("radio byte changed while stalled");
	a_last_valid: assert property (
		radio_tx_last_o |-> radio_tx_o.valid) else $error("last flag without byte");
	a_last_ends: assert property (
		radio_tx_o.valid && radio_tx_ready_i && radio_tx_last_o |=> !radio_tx_o.valid)
		else $error("bytes after last");
	a_rts_sending: assert property (
		radio_tx_o.valid |-> rts_n_o) else $error("host not paused while sending");
	a_ind_idle: assert property (
		data_indication_n_o |-> serial_tx_o) else $error("serial output without indication");
	a_fail_pulse: assert property (
		radio_failed_o |=> !radio_failed_o) else $error("failure flag too long");
	a_mode0_deliver: assert property (
		radio_rx_end_i && cfg_i.addressing_mode == 2'd0 && data_indication_n_o
		|-> ##[1:8] !data_indication_n_o) else $error("frame not delivered");
endmodule : urp_checker

// [verif/urp_host_model.sv]
`timescale 1ns/1ps
module urp_host_model (
	input  wire logic       clk_i,
	input  wire logic [7:0] fmt_i,
	input  wire logic       start_i,
	input  wire logic [7:0] byte_i,
	input  wire logic       bad_par_i,
	input  wire logic       rts_n_i,
	output logic            line_o,
	output logic            busy_o
);
	logic       q[$];
	logic [7:0] d;
	int         w;
	initial begin
		line_o = 1'b1;
		busy_o = 1'b0;
		forever begin
			@(posedge clk_i);
			if (start_i) begin
				busy_o <= 1'b1;
				// Hold off while the device asks for a pause
				for (w = 0; rts_n_i && w < 50000; w++)
					@(posedge clk_i);
				d = fmt_i[4] ? byte_i : {1'b0, byte_i[6:0]};
				q = {1'b0};
				for (int i = 0; i < (fmt_i[4] ? 8 : 7); i++)
					q.push_back(d[i]);
				if (fmt_i[7])
					q.push_back((fmt_i[6] ? ^d : ~^d) ^ bad_par_i);
				for (int i = 0; i < (fmt_i[5] ? 2 : 1); i++)
					q.push_back(1'b1);
				foreach (q[i]) begin
					line_o <= q[i];
					repeat (urp_pkg::BIT_CYCLES) @(posedge clk_i);
				end
				line_o <= 1'b1;
				busy_o <= 1'b0;
			end
		end
	end
endmodule : urp_host_model

// [verif/tb_urp_packetizer.sv]
`timescale 1ns/1ps
module tb_urp_packetizer;
	logic               clk = 1'b0;
	logic               rst_n = 1'b0;
	urp_pkg::urp_cfg_t  cfg;
	logic               line;
	logic               tx;
	logic               rts_n;
	logic               req_n = 1'b1;
	logic               ind_n;
	logic               set_addr = 1'b0;
	logic               set_net = 1'b0;
	logic [7:0]         cmd_val = 8'h00;
	urp_pkg::urp_byte_t rtx;
	logic               rlast;
	logic               rready = 1'b1;
	logic               failed;
	urp_pkg::urp_byte_t rrx = '0;
	logic               rend = 1'b0;
	logic               perr;
	logic               hstart = 1'b0;
	logic [7:0]         hbyte = 8'h00;
	logic               hbad = 1'b0;
	logic               hbusy;
	int                 miscompares = 0;
	int                 check_count = 0;

	initial begin
		forever #20 clk = ~clk;
	end

	urp_packetizer DUT (.clk_i(clk), .reset_n_i(rst_n), .cfg_i(cfg), .serial_rx_i(line), .serial_tx_o(tx),
		.rts_n_o(rts_n), .data_request_n_i(req_n), .data_indication_n_o(ind_n), .command_mode_i(1'b0),
		.command_start_seen_i(1'b0), .command_end_i(1'b0), .set_dest_network_command_i(set_net),
		.set_dest_address_command_i(set_addr), .command_value_i(cmd_val), .radio_tx_o(rtx),
		.radio_tx_last_o(rlast), .radio_ack_request_o(), .radio_tx_ready_i(rready), .radio_ack_i(1'b0),
		.radio_failed_o(failed), .radio_rx_i(rrx), .radio_rx_end_i(rend), .parity_error_o(perr));

	urp_host_model u_host (.clk_i(clk), .fmt_i(cfg.serial_format_setting), .start_i(hstart), .byte_i(hbyte),
		.bad_par_i(hbad), .rts_n_i(rts_n), .line_o(line), .busy_o(hbusy));

	task stop_test;
		if (miscompares == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test

	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task tmo(input string nm);
		miscompares++;
		$display("mismatch %s expected done seen timeout", nm);
		stop_test();
	endtask : tmo

	task send(input logic [7:0] b, input logic bad);
		int w;
		@(posedge clk);
		hbyte <= b;
		hbad <= bad;
		hstart <= 1'b1;
		@(posedge clk);
		hstart <= 1'b0;
		for (w = 0; w < 60000; w++) begin
			@(posedge clk);
			if (hbusy === 1'b0)
				break;
		end
		if (w == 60000)
			tmo("host send");
	endtask : send

	task rd_tx(input logic [7:0] e, input logic l);
		int i;
		for (i = 0; i < 60000; i++) begin
			@(posedge clk);
			if (rtx.valid === 1'b1 && rready === 1'b1)
				break;
		end
		if (i == 60000)
			tmo("radio byte");
		chk("radio byte", e, rtx.data);
		chk("last flag", {7'h00, l}, {7'h00, rlast});
	endtask : rd_tx

	task rx3(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
		@(posedge clk);
		rrx <= '{1'b1, a};
		@(posedge clk);
		rrx <= '{1'b1, b};
		@(posedge clk);
		rrx <= '{1'b1, c};
		@(posedge clk);
		rrx <= '0;
		rend <= 1'b1;
		@(posedge clk);
		rend <= 1'b0;
	endtask : rx3

	task wait_ind(input logic v, input int n);
		int i;
		for (i = 0; i < n; i++) begin
			@(posedge clk);
			if (ind_n === v)
				break;
		end
		if (i == n)
			tmo("indication");
		chk("indication", {7'h00, v}, {7'h00, ind_n});
	endtask : wait_ind

	task rd_ser(input logic [7:0] e);
		int i;
		logic [7:0] v;
		for (i = 0; i < 30000 && tx !== 1'b0; i++)
			@(posedge clk);
		if (i == 30000)
			tmo("serial start");
		repeat (urp_pkg::BIT_CYCLES / 2) @(posedge clk);
		for (i = 0; i < 8; i++) begin
			repeat (urp_pkg::BIT_CYCLES) @(posedge clk);
			v[i] = tx;
		end
		repeat (urp_pkg::BIT_CYCLES) @(posedge clk);
		chk("serial byte", e, v);
		chk("serial stop", 8'h01, {7'h00, tx});
	endtask : rd_ser

	task s_size;
		@(posedge clk);
		cfg.packet_method <= 1'b1;
		cfg.max_packet_bytes <= 8'h02;
		cfg.addressing_mode <= 2'd1;
		rready <= 1'b0;
		send(8'h11, 1'b0);
		send(8'h22, 1'b0);
		repeat (20) @(posedge clk);
		rready <= 1'b1;
		rd_tx(8'h34, 1'b0);
		rd_tx(8'h78, 1'b0);
		rd_tx(8'h11, 1'b0);
		rd_tx(8'h22, 1'b1);
	endtask : s_size

	task s_etx;
		@(posedge clk);
		cfg.max_packet_bytes <= 8'h80;
		cfg.addressing_mode <= 2'd2;
		cfg.serial_format_setting <= 8'h30;
		rready <= 1'b0;
		cmd_val <= 8'h44;
		set_net <= 1'b1;
		@(posedge clk);
		set_net <= 1'b0;
		cmd_val <= 8'h33;
		set_addr <= 1'b1;
		@(posedge clk);
		set_addr <= 1'b0;
		send(8'h5a, 1'b0);
		send(8'h0a, 1'b0);
		rready <= 1'b1;
		rd_tx(8'h44, 1'b0);
		rd_tx(8'h33, 1'b0);
		rd_tx(8'h56, 1'b0);
		rd_tx(8'h78, 1'b0);
		rd_tx(8'h5a, 1'b0);
		rd_tx(8'h0a, 1'b1);
	endtask : s_etx

	task s_idle;
		@(posedge clk);
		cfg.packet_method <= 1'b0;
		cfg.addressing_mode <= 2'd0;
		cfg.serial_format_setting <= 8'h10;
		cfg.idle_timeout_ms <= 16'd2;
		send(8'hc3, 1'b0);
		chk("early launch", 8'h00, {7'h00, rtx.valid});
		rd_tx(8'hc3, 1'b1);
	endtask : s_idle

	task s_req;
		@(posedge clk);
		cfg.packet_method <= 1'b1;
		cfg.serial_format_setting <= 8'h00;
		cfg.radio_retry_count <= 8'h01;
		cfg.acknowledge_wait_time <= 16'h0000;
		send(8'hc1, 1'b0);
		req_n <= 1'b0;
		repeat (4) @(posedge clk);
		req_n <= 1'b1;
		rd_tx(8'h41, 1'b1);
		rd_tx(8'h41, 1'b1);
		for (int i = 0; i < 8 && failed !== 1'b1; i++)
			@(posedge clk);
		chk("failed", 8'h01, {7'h00, failed});
	endtask : s_req

	task s_par;
		@(posedge clk);
		cfg.serial_format_setting <= 8'hd0;
		send(8'h03, 1'b1);
		repeat (5) @(posedge clk);
		chk("parity error", 8'h01, {7'h00, perr});
		cfg.serial_format_setting <= 8'h90;
		send(8'h05, 1'b0);
		repeat (5) @(posedge clk);
		chk("parity error", 8'h00, {7'h00, perr});
	endtask : s_par

	task s_rx;
		@(posedge clk);
		cfg.addressing_mode <= 2'd1;
		cfg.serial_format_setting <= 8'h10;
		rx3(8'h99, 8'h01, 8'haa);
		repeat (40) @(posedge clk);
		chk("indication", 8'h01, {7'h00, ind_n});
		rx3(8'hff, 8'h01, 8'haa);
		wait_ind(1'b0, 50);
		rd_ser(8'haa);
		wait_ind(1'b1, 20000);
		@(posedge clk);
		cfg.addressing_mode <= 2'd0;
		rx3(8'h01, 8'h02, 8'h03);
		wait_ind(1'b0, 50);
	endtask : s_rx

	initial begin
		cfg = '0;
		cfg.serial_format_setting = 8'h10;
		cfg.flow_stop_threshold = 8'h70;
		cfg.max_packet_bytes = 8'h80;
		cfg.end_of_text_value = 8'h0a;
		cfg.default_dest_network = 8'h12;
		cfg.default_dest_address = 8'h34;
		cfg.own_network_id = 8'h56;
		cfg.own_device_address = 8'h78;
		cfg.acknowledge_wait_time = 16'h0001;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		s_size();
		s_etx();
		s_idle();
		s_req();
		s_par();
		s_rx();
		stop_test();
	end
endmodule : tb_urp_packetizer

bind urp_packetizer urp_checker u_chk (.clk_i(clk_i), .reset_n_i(reset_n_i), .cfg_i(cfg_i),
	.serial_tx_o(serial_tx_o), .rts_n_o(rts_n_o), .data_indication_n_o(data_indication_n_o),
	.radio_tx_o(radio_tx_o), .radio_tx_last_o(radio_tx_last_o), .radio_ack_request_o(radio_ack_request_o),
	.radio_tx_ready_i(radio_tx_ready_i), .radio_failed_o(radio_failed_o), .radio_rx_end_i(radio_rx_end_i));
